//--- design/ttl_client.sv
// Client side timeslot counter, duplex control, Manchester line coding and failover.
`timescale 1ns/100ps
`include "ttl_params.svh"

// Notes on behaviour
// - Both directions share one pair; transmit and receive alternate.
// - Line bits are Manchester coded at 5 Mbps, locked to master clock.
// - A timeslot is 1024 master clocks, 102.4 us.
// - A bit spans two master counts starting on an even count; 512 bits.
// - Bit slot index is (timestamp mod 1024) divided by two.
// - Client counts bit slots continuously, wrapping modulo 512.
// - First received server preamble bit marks bit slot 0.
// - Client transmits its first preamble bit in bit slot 256.
// - Slot splits in server half and client half; one side drives.
// - Frames are 234 bits, followed by 22 idle guard bits.
// - Client finishes CRC and turns to transmit inside first guard.
// - Guard after client frame covers cable round trip; client stays off.
// - Client output timing advanced by the cable advance correction.
// - Received data held and released only after CRC check passes.
// - Failover to protection input waits at least 500 ms after loss.
// - CRC is 16 bits over payload only, preamble excluded.
// - Frame clock rise aligns with the first preamble bit.
// - Most significant bit of every field goes first on the line.
module ttl_client
#(
  parameter int MCLK_DIV     = 4,
  parameter int PAYLOAD_BITS = `TTL_FRAME_BITS - `TTL_PREAMBLE_BITS - `TTL_CRC_BITS,
  parameter int FAILOVER_CYC = `TTL_FAILOVER_CYC
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Line pin, shared pair
  input  wire logic                    line_in,
  output logic                         line_out,
  output logic                         line_oe,
  // Cable advance correction, in master clocks
  input  wire logic [9:0]              cable_advance,
  // Transmit payload, sampled at the start of the client frame
  input  wire logic [PAYLOAD_BITS-1:0] tx_payload,
  // Released receive data
  output logic [PAYLOAD_BITS-1:0]      rx_payload,
  output logic                         rx_valid,
  output logic                         rx_crc_error,
  // Timing and status
  output logic [31:0]                  timestamp_counter,
  output logic [8:0]                   bit_slot,
  output ttl_pkg::ttl_phase_t          phase,
  output logic                         frame_clk,
  output logic                         locked,
  output logic                         failover
);
  import ttl_pkg::*;

  localparam logic [67:0] PREAMBLE = 68'hA_AAAA_AAAA_AAAA_AAA9;
  localparam int CRC_END = `TTL_FRAME_BITS;

  // Pin synchroniser; only the second stage is read.
  logic sync1, sync2, line_prev;
  // Master clock enable derived from the 40 MHz clock.
  logic [$clog2(MCLK_DIV)-1:0] div_cnt, next_div_cnt;
  logic mtick;
  logic [31:0] next_timestamp;
  logic locked_q, next_locked;
  logic [8:0] rx_bit, next_rx_bit;
  logic [15:0] crc, next_crc;
  logic [PAYLOAD_BITS-1:0] shreg, next_shreg;
  logic [PAYLOAD_BITS-1:0] tx_sh, next_tx_sh;
  logic mem_wr;
  logic next_rx_valid, next_rx_err;
  logic [31:0] loss_cnt, next_loss_cnt;
  logic next_failover;
  logic next_line_out, next_line_oe;
  logic [9:0] tx_pos;
  logic [8:0] tx_slot;
  logic rx_sample;
  logic rx_in_frame;
  logic [1:0] settle, next_settle;
  logic lock_edge;
  logic [15:0] tx_crc, next_tx_crc;
  logic [8:0] tx_off;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      line_prev <= 1'b0;
    end else begin
      sync1 <= line_in;
      sync2 <= sync1;
      line_prev <= sync2;
    end
  end

  // The divider restarts on the lock edge so that every data sample falls
  // in the middle of the second half of a received bit.
  always_comb begin
    next_div_cnt = (div_cnt == $bits(div_cnt)'(MCLK_DIV - 1)) ? '0 : div_cnt + 1'b1;
    if (lock_edge) begin
      next_div_cnt = '0;
    end
    next_settle = settle + {1'b0, settle != 2'h3};
  end
  assign mtick = (div_cnt == '0);

  // Edges count only once both sync stages and the previous-level flop hold pin
  // values, otherwise an idle high line would look like an edge after reset.
  assign lock_edge = !locked_q && settle == 2'h3 && sync2 != line_prev;

  // The timestamp runs freely; the first preamble edge only realigns it.
  always_comb begin
    next_timestamp = timestamp_counter;
    next_locked = locked_q;
    if (lock_edge) begin
      next_timestamp = '0;
      next_locked = 1'b1;
    end else if (mtick) begin
      next_timestamp = timestamp_counter + 32'h0000_0001;
    end
  end

  assign bit_slot = timestamp_counter[9:1];
  assign rx_sample = mtick && timestamp_counter[0];
  assign rx_in_frame = bit_slot < 9'(`TTL_FRAME_BITS);
  assign frame_clk = (timestamp_counter[9:0] < 10'h200);

  always_comb begin
    if (bit_slot < 9'(`TTL_FRAME_BITS)) phase = TTL_RX_HALF;
    else if (bit_slot < `TTL_CLIENT_FIRST) phase = TTL_RX_GUARD;
    else if (bit_slot < 9'(`TTL_CLIENT_FIRST + `TTL_FRAME_BITS)) phase = TTL_TX_HALF;
    else phase = TTL_TX_GUARD;
  end

  // Receive: second half of each Manchester bit carries the data value.
  always_comb begin
    next_rx_bit = rx_bit;
    next_crc = crc;
    next_shreg = shreg;
    mem_wr = 1'b0;
    next_rx_valid = 1'b0;
    next_rx_err = 1'b0;
    if (rx_sample && locked_q) begin
      if (bit_slot == `TTL_SERVER_FIRST) begin
        next_rx_bit = 9'h001;
        next_crc = `TTL_CRC_INIT;
      end else if (rx_in_frame) begin
        next_rx_bit = rx_bit + 9'h001;
        if (rx_bit >= 9'(`TTL_PREAMBLE_BITS)) begin
          next_crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ sync2) ? `TTL_CRC_POLY : 16'h0000);
          if (rx_bit < 9'(`TTL_FRAME_BITS - `TTL_CRC_BITS)) begin
            next_shreg = {shreg[PAYLOAD_BITS-2:0], sync2};
          end
        end
      end
    end
    if (rx_sample && locked_q && bit_slot == 9'(CRC_END)) begin
      mem_wr = (crc == 16'h0000);
      next_rx_valid = (crc == 16'h0000);
      next_rx_err = (crc != 16'h0000);
    end
  end

  ttl_frame_mem #(.WIDTH(PAYLOAD_BITS)) u_mem (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (mem_wr),
    .wr_data (shreg),
    .rd_data (rx_payload)
  );

  // Transmit slot is measured on advanced timing.
  assign tx_pos = timestamp_counter[9:0] + cable_advance;
  assign tx_slot = tx_pos[9:1];
  // Offset within the client frame; slots before the frame wrap to large values.
  assign tx_off = tx_slot - `TTL_CLIENT_FIRST;

  always_comb begin
    next_line_oe = 1'b0;
    next_line_out = 1'b0;
    next_tx_sh = tx_sh;
    next_tx_crc = tx_crc;
    if (locked_q && tx_off < 9'(`TTL_FRAME_BITS)) begin
      next_line_oe = 1'b1;
      if (tx_off < 9'(`TTL_PREAMBLE_BITS)) begin
        next_line_out = PREAMBLE[7'(67 - tx_off)] ^ ~tx_pos[0];
      end else if (tx_off < 9'(`TTL_FRAME_BITS - `TTL_CRC_BITS)) begin
        next_line_out = tx_sh[PAYLOAD_BITS-1] ^ ~tx_pos[0];
      end else begin
        next_line_out = tx_crc[15] ^ ~tx_pos[0];
      end
    end
    if (mtick && tx_pos[0] && locked_q) begin
      if (tx_off == 9'h000) begin
        next_tx_sh = tx_payload;
        next_tx_crc = `TTL_CRC_INIT;
      end else if (tx_off >= 9'(`TTL_PREAMBLE_BITS) &&
                   tx_off < 9'(`TTL_FRAME_BITS - `TTL_CRC_BITS)) begin
        next_tx_sh = {tx_sh[PAYLOAD_BITS-2:0], 1'b0};
        next_tx_crc = {tx_crc[14:0], 1'b0} ^
                      ((tx_crc[15] ^ tx_sh[PAYLOAD_BITS-1]) ? `TTL_CRC_POLY : 16'h0000);
      end else if (tx_off >= 9'(`TTL_FRAME_BITS - `TTL_CRC_BITS) &&
                   tx_off < 9'(`TTL_FRAME_BITS)) begin
        next_tx_crc = {tx_crc[14:0], 1'b0};
      end
    end
  end

  // Loss of valid frames arms failover only after the full timeout.
  always_comb begin
    next_loss_cnt = loss_cnt;
    next_failover = failover;
    if (next_rx_valid) begin
      next_loss_cnt = '0;
      next_failover = 1'b0;
    end else if (loss_cnt < 32'(FAILOVER_CYC)) begin
      next_loss_cnt = loss_cnt + 32'h0000_0001;
    end else begin
      next_failover = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt <= '0;
      timestamp_counter <= '0;
      locked_q <= 1'b0;
      rx_bit <= '0;
      crc <= `TTL_CRC_INIT;
      shreg <= '0;
      tx_sh <= '0;
      tx_crc <= `TTL_CRC_INIT;
      settle <= '0;
      rx_valid <= 1'b0;
      rx_crc_error <= 1'b0;
      loss_cnt <= '0;
      failover <= 1'b0;
      line_out <= 1'b0;
      line_oe <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      timestamp_counter <= next_timestamp;
      locked_q <= next_locked;
      rx_bit <= next_rx_bit;
      crc <= next_crc;
      shreg <= next_shreg;
      tx_sh <= next_tx_sh;
      tx_crc <= next_tx_crc;
      settle <= next_settle;
      rx_valid <= next_rx_valid;
      rx_crc_error <= next_rx_err;
      loss_cnt <= next_loss_cnt;
      failover <= next_failover;
      line_out <= next_line_out;
      line_oe <= next_line_oe;
    end
  end

  assign locked = locked_q;
endmodule // ttl_client

//--- design/ttl_frame_mem.sv
// Holding buffer for one received frame payload, released after its check.
`timescale 1ns/100ps
module ttl_frame_mem #(
  parameter int WIDTH = 150
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] store;
  logic [WIDTH-1:0] next_store;

  always_comb begin
    next_store = wr_en ? wr_data : store;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      store <= '0;
    end else begin
      store <= next_store;
    end
  end

  assign rd_data = store;
endmodule // ttl_frame_mem

//--- design/ttl_params.svh
// Constants for the timeslot and duplex framing block.
`ifndef TTL_PARAMS_SVH
`define TTL_PARAMS_SVH
`define TTL_CLK_HZ          40000000
`define TTL_MCLK_PER_SLOT   1024
`define TTL_BITS_PER_SLOT   512
`define TTL_SERVER_FIRST    9'h000
`define TTL_CLIENT_FIRST    9'h100
`define TTL_FRAME_BITS      234
`define TTL_GUARD_BITS      22
`define TTL_CRC_BITS        16
`define TTL_PREAMBLE_BITS   68
`define TTL_FAILOVER_MS     500
`define TTL_FAILOVER_CYC    ((`TTL_CLK_HZ / 1000) * `TTL_FAILOVER_MS)
`define TTL_CRC_POLY        16'h1021
`define TTL_CRC_INIT        16'hFFFF
`endif

//--- design/ttl_pkg.sv
// Types shared by the timeslot and duplex framing block.
package ttl_pkg;
  typedef enum logic [1:0] {
    TTL_RX_HALF,
    TTL_RX_GUARD,
    TTL_TX_HALF,
    TTL_TX_GUARD
  } ttl_phase_t;
endpackage

//--- tb/tb.sv
// Self-checking bench for the client framing block.
`timescale 1ns/100ps
module tb;
  import ttl_pkg::*;
  localparam int FOC = 6000;
  logic         clk, rst_n, line_in, line_out, line_oe, rx_valid, rx_crc_error;
  logic         frame_clk, locked, failover, en, bad, srv;
  logic [9:0]   cable_advance;
  logic [8:0]   bit_slot;
  logic [31:0]  timestamp_counter;
  logic [149:0] pay, tx_payload, rx_payload, exp_pay;
  logic [159:0] rnd;
  logic [233:0] heard;
  ttl_phase_t   phase;
  int           n_mismatch, checks, seed, oe_n, oe_prev, k;
  assign line_in = line_oe ? line_out : srv;
  ttl_client #(.FAILOVER_CYC(FOC)) u_dut (.*);
  ttl_server_model u_srv (.clk(clk), .en(en), .bad(bad), .pay(pay), .adv(cable_advance),
                          .pair(line_in), .line(srv), .heard(heard));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) oe_n <= oe_n + int'(line_oe === 1'b1);
  // Client frame as it must appear on the pair: preamble, payload, check word.
  function automatic logic [233:0] frame_of(input logic [149:0] d);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int j = 149; j >= 0; j--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[j]) ? 16'h1021 : 16'h0000);
    end
    return {68'hAAAA_AAAA_AAAA_AAAA_9, d, c};
  endfunction
  task automatic chk(input logic [233:0] got, input logic [233:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_result;
    k = 0;
    @(negedge clk);
    while (rx_valid !== 1'b1 && rx_crc_error !== 1'b1 && k < 9000) begin
      @(negedge clk);
      k++;
    end
    if (k == 9000) begin
      n_mismatch++;
      test_done;
    end
  endtask
  initial begin
    seed = 61;
    {n_mismatch, checks, oe_n, oe_prev} = '0;
    {rst_n, en, bad} = 3'h0;
    cable_advance = 10'h000;
    {pay, tx_payload, exp_pay} = '0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk({locked, bit_slot}, '0);
    for (int i = 0; i < 6; i++) begin
      rnd = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      pay = (i == 1) ? '1 : rnd[149:0];
      tx_payload = rnd[159:10];
      bad = (i == 3);
      en = 1'b1;
      wait_result;
      chk({rx_valid, rx_crc_error}, {!bad, bad});
      if (!bad) exp_pay = pay;
      chk(rx_payload, exp_pay);
      chk({phase, frame_clk}, {TTL_RX_GUARD, 1'b1});
      if (i > 0) chk(heard, frame_of(tx_payload));
      if (i > 0) chk(oe_n - oe_prev, 1872);
      oe_prev = oe_n;
      if (i == 4) cable_advance = {6'h00, rnd[3:0]};
    end
    chk(locked, 1'b1);
    en = 1'b0;
    k = 0;
    while (failover !== 1'b1 && k < FOC + 4096) begin
      @(negedge clk);
      k++;
    end
    chk(k >= FOC - 2 && k <= FOC + 8, 1'b1);
    test_done;
  end
endmodule // tb

//--- tb/ttl_client_sva.sv
// Port checker for the client framing block.
`timescale 1ns/100ps
module ttl_client_sva #(
  parameter int PAYLOAD_BITS = 150,
  parameter int FAILOVER_CYC = 6000
) (
  // Clock
  input wire logic                    clk,
  input wire logic                    rst_n,
  // Line
  input wire logic                    line_oe,
  input wire logic [9:0]              cable_advance,
  // Results
  input wire logic [PAYLOAD_BITS-1:0] rx_payload,
  input wire logic                    rx_valid,
  input wire logic                    rx_crc_error,
  // Status
  input wire logic [31:0]             timestamp_counter,
  input wire logic [8:0]              bit_slot,
  input wire logic                    locked,
  input wire logic                    failover
);
  logic [15:0] quiet;
  logic [15:0] next_quiet;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Saturates so a long quiet spell cannot wrap into a short one.
  always_comb begin
    next_quiet = (!rst_n || rx_valid) ? 16'h0000 : quiet + {15'h0000, quiet != 16'hFFFF};
  end
  always_ff @(posedge clk) begin
    quiet <= next_quiet;
  end
  AST_SLOT_MAP: assert property (bit_slot == timestamp_counter[9:1])
    else $error("bit slot off timestamp");
  AST_TICK: assert property (locked && $past(locked) && $changed(timestamp_counter)
    |=> $stable(timestamp_counter)[*3]) else $error("master tick not four clocks");
  AST_OE_WIN: assert property (line_oe && cable_advance == 10'h000
    |-> bit_slot inside {[256:490]}) else $error("driving outside client half");
  AST_FAILOVER: assert property ($rose(failover) |-> quiet >= FAILOVER_CYC - 2)
    else $error("failover too early");
  AST_GAP: assert property (rx_valid || rx_crc_error
    |=> !(rx_valid || rx_crc_error)[*8]) else $error("result pulse too long");
  AST_ERR_KEEP: assert property (rx_crc_error |-> $stable(rx_payload) && !rx_valid)
    else $error("bad frame reached output");
  AST_PAY_CHG: assert property ($changed(rx_payload) |-> rx_valid)
    else $error("payload changed without valid");
  AST_GUARD: assert property (rx_valid || rx_crc_error
    |-> bit_slot inside {[233:255]}) else $error("result outside guard");
endmodule // ttl_client_sva

bind ttl_client ttl_client_sva #(
  .PAYLOAD_BITS(PAYLOAD_BITS), .FAILOVER_CYC(FAILOVER_CYC)) u_sva (.*);

//--- tb/ttl_server_model.sv
// Behavioural timing server sending one frame per timeslot on the pair.
`timescale 1ns/100ps
module ttl_server_model (
  // Clock and frame control
  input  wire logic         clk,
  input  wire logic         en,
  input  wire logic         bad,
  input  wire logic [149:0] pay,
  input  wire logic [9:0]   adv,
  // Pair level seen by both ends, and the server's own level
  input  wire logic         pair,
  output logic              line,
  // Client frame heard on the pair, first bit in the top position
  output logic [233:0]      heard
);
  logic [233:0] frm;
  logic [11:0]  cnt;
  logic [11:0]  v;
  logic [8:0]   b;
  logic         hold;
  function automatic logic [15:0] crc16(input logic [149:0] d);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 149; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction
  initial begin
    frm = '0;
    cnt = '0;
    hold = 1'b0;
    heard = '0;
  end
  // A timeslot is 1024 master clocks of four clocks each.
  always @(posedge clk) begin
    if (en || cnt != 12'h000) cnt <= cnt + 12'h001;
    // A bad frame flips one payload bit after its check word was formed.
    if (en && cnt == 12'h000)
      frm <= {68'hAAAA_AAAA_AAAA_AAAA_9, pay ^ {149'h0, bad}, crc16(pay)};
    // Idle level follows the last bit sent, not a frame loaded for later.
    if (b < 9'h0EA) hold <= frm[9'h0E9 - b];
    // The client runs adv master clocks early, so its bits are sampled that much earlier.
    if (v[2:0] == 3'h7 && v[11:3] >= 9'h101 && v[11:3] <= 9'h1EA)
      heard <= {heard[232:0], pair};
  end
  assign b = cnt[11:3] - 9'h001;
  assign v = cnt + {adv, 2'b00};
  // Released pair shows the inverse of the last level, never a stale one.
  assign line = (b < 9'h0EA) ? (frm[9'h0E9 - b] ^ ~cnt[2]) : ~hold;
endmodule // ttl_server_model
